/* File: design/wpf_params.svh */
// Wake packet filter constants, register map and timing counts
// What this block does
// - Armed frames pass standard address filter, then an enabled wake filter, to wake.
// - Every matching filter sets its own received bit in wake status.
// - Link-change enable bit 0 makes a link state change wake and set status.
// - No wake filtering until software sets the wake-mode enable bit.
// - With packet store enabled, the frame causing the wake is captured.
// - Stored frame length is readable; zero means nothing was captured.
// - Stored bytes 0 to 63 readable once software clears host wake.
// - Writing the stored-frame clear location drops the captured indication.
// - Each predefined filter works only while its enable bit is one.
// - Management-matched frames wake only if allowed by the management control bits.
// - Directed exact enable wakes on destination equal to a valid receive address.
// - Multicast wake indexes the multicast table with offset-selected destination bits.
// - Broadcast enable wakes on an all-ones six byte destination.
// - Address pattern only considered for broadcast, address zero or filter-passing destinations.
// - Pattern needs six or more 0xff bytes; next non-0xff byte starts address.
// - Pattern valid only if next 96 bytes are sixteen destination address copies (receive address zero copies for broadcast).
// - Broadcast passes address filtering for pattern wake even without broadcast accept.
// - Sync run and address copies may start at any byte after the six destination bytes.
// - Pattern frame also needs a valid address and a good CRC.
// - Nonvolatile pattern enable loads receive address zero at startup.
// - A matching pattern frame sets its status bit and signals a wake.
// - Wake event repeats every 50 ms while pending and host wake unchanged.
`ifndef WPF_PARAMS_SVH
`define WPF_PARAMS_SVH
`define WPF_REG_CTRL 7'h00
`define WPF_REG_STORE 7'h01
`define WPF_REG_WFC 7'h02
`define WPF_REG_WSTAT 7'h03
`define WPF_REG_RECEIVE_CONTROL 7'h04
`define WPF_REG_MGMT 7'h05
`define WPF_REG_RA0L 7'h06
`define WPF_REG_RA0H 7'h07
`define WPF_REG_MTA0 7'h08
`define WPF_REG_MTA1 7'h09
`define WPF_REG_PLEN 7'h0a
`define WPF_REG_PCLR 7'h0b
`define WPF_CTRL_MODE_BIT 2
`define WPF_CTRL_HOST_BIT 4
`define WPF_STORE_EN_BIT 4
`define WPF_WFC_NOMGMT_BIT 11
`define WPF_RECEIVE_CONTROL_MCOFF_LSB 3
`define WPF_RECEIVE_CONTROL_BAM_BIT 5
`define WPF_RA_VALID_BIT 31
`define WPF_ST_LINK 0
`define WPF_ST_PAT 1
`define WPF_ST_EXACT 2
`define WPF_ST_MC 3
`define WPF_ST_BC 4
`define WPF_SYNC_LEN 3'h6
`define WPF_COPIES_LAST 4'hf
`define WPF_RESEND_MS 50
`define WPF_CLK_NS 4
`endif

/* File: design/wpf_pkg.sv */
// Wake packet filter types
package wpf_pkg;
  typedef logic [7:0] wpf_byte_t;
  typedef enum logic [1:0] {
    WPF_SYNC = 2'b00,
    WPF_MATCH = 2'b01,
    WPF_FOUND = 2'b10
  } wpf_scan_t;
  typedef struct packed {
    wpf_scan_t st;
    logic [2:0] ff_cnt;
    logic [2:0] pos;
    logic [3:0] copies;
  } wpf_scan_st_t;
  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [15:0] cnt;
    logic [15:0] len;
    logic cap;
  } wpf_store_st_t;
  typedef struct packed {
    logic init;
    logic waitreq;
    logic [31:0] rdata;
    logic mode_en;
    logic host_wake;
    logic store_en;
    logic [11:0] wfc;
    logic [4:0] wstat;
    logic [1:0] mc_off;
    logic bam;
    logic host_only;
    logic [47:0] ra0;
    logic ra0_v;
    logic [63:0] mta;
    logic [2:0] bcnt;
    logic [47:0] da;
    logic eval;
    logic ev_crc;
    logic ev_mgmt;
    logic ev_m2h;
    logic link_d;
    logic wake_ev;
    logic pend;
    logic [23:0] tmr;
  } wpf_top_st_t;
endpackage

/* File: design/wpf_pattern_scan.sv */
// Sixteen-copy address pattern scanner
`timescale 1ns/1ns
`default_nettype none
`include "wpf_params.svh"
module wpf_pattern_scan (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Byte stream
  input wire logic start,
  input wire logic valid,
  input wire wpf_pkg::wpf_byte_t data,
  input wire logic [47:0] target,
  // Result
  output logic found
);
  import wpf_pkg::*;
  wpf_scan_st_t s_reg, s_next;
  wpf_byte_t exp_byte;

  always_comb begin
    s_next = s_reg;
    exp_byte = target[8*(5-s_reg.pos) +: 8];
    if (start) begin
      s_next = '0;
    end else if (valid) begin
      case (s_reg.st)
        WPF_SYNC: begin
          if (data == 8'hff) begin
            if (s_reg.ff_cnt != `WPF_SYNC_LEN) s_next.ff_cnt = s_reg.ff_cnt + 3'h1;
          end else if (s_reg.ff_cnt == `WPF_SYNC_LEN && data == exp_byte) begin
            s_next.st = WPF_MATCH;
            s_next.pos = 3'h1;
            s_next.copies = 4'h0;
          end else begin
            s_next.ff_cnt = 3'h0;
          end
        end
        WPF_MATCH: begin
          if (data == exp_byte) begin
            if (s_reg.pos == 3'h5) begin
              s_next.pos = 3'h0;
              if (s_reg.copies == `WPF_COPIES_LAST) s_next.st = WPF_FOUND;
              else s_next.copies = s_reg.copies + 4'h1;
            end else begin
              s_next.pos = s_reg.pos + 3'h1;
            end
          end else begin
            // Broken copy, hunt again from here
            s_next.st = WPF_SYNC;
            s_next.pos = 3'h0;
            s_next.copies = 4'h0;
            s_next.ff_cnt = (data == 8'hff) ? 3'h1 : 3'h0;
          end
        end
        WPF_FOUND: s_next = s_reg;
        default: s_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign found = (s_reg.st == WPF_FOUND);
endmodule
`default_nettype wire

/* File: design/wpf_frame_store.sv */
// Wake frame storage, 64 bytes with length
`timescale 1ns/1ns
`default_nettype none
module wpf_frame_store (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Frame bytes
  input wire logic wr_valid,
  input wire logic wr_sof,
  input wire wpf_pkg::wpf_byte_t wr_data,
  // Control
  input wire logic commit,
  input wire logic clear,
  // Read side
  input wire logic [5:0] rd_idx,
  output wpf_pkg::wpf_byte_t rd_data,
  output logic captured,
  output logic [15:0] length
);
  import wpf_pkg::*;
  wpf_store_st_t s_reg, s_next;
  logic [15:0] idx;

  always_comb begin
    s_next = s_reg;
    idx = wr_sof ? 16'h0 : s_reg.cnt;
    // Held frame is frozen until cleared
    if (wr_valid && !s_reg.cap && !commit) begin
      if (idx < 16'd64) s_next.mem[idx[5:0]] = wr_data;
      if (idx != 16'hffff) s_next.cnt = idx + 16'h1;
    end
    if (clear) begin
      s_next.cap = 1'b0;
      s_next.len = 16'h0;
    end
    if (commit) begin
      s_next.cap = 1'b1;
      s_next.len = s_reg.cnt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign rd_data = s_reg.mem[rd_idx];
  assign captured = s_reg.cap;
  assign length = s_reg.len;
endmodule
`default_nettype wire

/* File: design/wpf_top.sv */
// Wake packet filter top with Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
`include "wpf_params.svh"
module wpf_top #(
  parameter int RESEND_CYCLES = `WPF_RESEND_MS * 1000000 / `WPF_CLK_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Receive byte stream
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire wpf_pkg::wpf_byte_t rx_data,
  input wire logic rx_crc_ok,
  input wire logic mgmt_filter_pass,
  input wire logic mgmt_to_host,
  // Link and startup configuration
  input wire logic link_up,
  input wire logic nvm_pattern_wake_en,
  input wire logic [47:0] nvm_station_addr,
  // Wake event to LAN controller
  output logic wake_event
);
  import wpf_pkg::*;
  wpf_top_st_t s_reg, s_next;
  logic req, acc, wr_acc, hw_chg, expire, commit, pclr;
  logic is_bc, exact, is_mc, addr_ok, pat_addr, mgmt_ok, qual, link_hit;
  logic [4:0] hits;
  logic [5:0] mc_idx;
  logic found, captured, scan_start, scan_valid;
  logic [15:0] plen;
  wpf_byte_t pkt_byte;
  logic [47:0] scan_target;

  // ****************************************
  // Address pattern scanner and frame store
  // ****************************************
  assign scan_start = rx_valid && rx_sof;
  assign scan_valid = rx_valid && !rx_sof && (s_reg.bcnt == 3'h6);
  // Broadcast frames carry the station address in the pattern
  assign scan_target = is_bc ? s_reg.ra0 : s_reg.da;

  wpf_pattern_scan u_scan (
    .clk(clk),
    .rst_n(rst_n),
    .start(scan_start),
    .valid(scan_valid),
    .data(rx_data),
    .target(scan_target),
    .found(found)
  );

  wpf_frame_store u_store (
    .clk(clk),
    .rst_n(rst_n),
    .wr_valid(rx_valid),
    .wr_sof(rx_sof),
    .wr_data(rx_data),
    .commit(commit),
    .clear(pclr),
    .rd_idx(avs_address[5:0]),
    .rd_data(pkt_byte),
    .captured(captured),
    .length(plen)
  );

  // ****************************************
  // Filters, status, bus and resend timer
  // ****************************************
  always_comb begin
    s_next = s_reg;
    // Address filters on the captured destination
    is_bc = &s_reg.da;
    exact = s_reg.ra0_v && (s_reg.da == s_reg.ra0);
    mc_idx = 6'(s_reg.da[15:0] >> {s_reg.mc_off, 1'b0});
    is_mc = s_reg.da[40] && !is_bc && s_reg.mta[mc_idx];
    addr_ok = exact || is_mc || (is_bc && s_reg.bam);
    pat_addr = exact || is_mc || is_bc;
    mgmt_ok = !s_reg.ev_mgmt || !s_reg.wfc[`WPF_WFC_NOMGMT_BIT]
              || (s_reg.host_only && s_reg.ev_m2h);
    qual = s_reg.eval && s_reg.mode_en && s_reg.ev_crc && mgmt_ok;
    hits = 5'h0;
    hits[`WPF_ST_PAT] = qual && s_reg.wfc[`WPF_ST_PAT] && pat_addr && found;
    hits[`WPF_ST_EXACT] = qual && s_reg.wfc[`WPF_ST_EXACT] && exact;
    hits[`WPF_ST_MC] = qual && s_reg.wfc[`WPF_ST_MC] && is_mc;
    hits[`WPF_ST_BC] = qual && s_reg.wfc[`WPF_ST_BC] && is_bc && addr_ok;
    link_hit = s_reg.mode_en && s_reg.wfc[`WPF_ST_LINK] && (link_up != s_reg.link_d);
    commit = (|hits) && s_reg.store_en && !captured;

    // Bus handshake: one wait cycle, then a one-cycle answer
    req = avs_read || avs_write;
    acc = req && !s_reg.waitreq;
    wr_acc = acc && avs_write;
    s_next.waitreq = !(req && s_reg.waitreq);
    pclr = wr_acc && (avs_address == `WPF_REG_PCLR);
    hw_chg = wr_acc && (avs_address == `WPF_REG_CTRL)
             && (avs_writedata[`WPF_CTRL_HOST_BIT] != s_reg.host_wake);
    if (req && s_reg.waitreq && avs_read) begin
      s_next.rdata = 32'h0;
      case (avs_address)
        `WPF_REG_CTRL: begin
          s_next.rdata[`WPF_CTRL_MODE_BIT] = s_reg.mode_en;
          s_next.rdata[`WPF_CTRL_HOST_BIT] = s_reg.host_wake;
        end
        `WPF_REG_STORE: s_next.rdata[`WPF_STORE_EN_BIT] = s_reg.store_en;
        `WPF_REG_WFC: s_next.rdata[11:0] = s_reg.wfc;
        `WPF_REG_WSTAT: s_next.rdata[4:0] = s_reg.wstat;
        `WPF_REG_RECEIVE_CONTROL: begin
          s_next.rdata[`WPF_RECEIVE_CONTROL_MCOFF_LSB +: 2] = s_reg.mc_off;
          s_next.rdata[`WPF_RECEIVE_CONTROL_BAM_BIT] = s_reg.bam;
        end
        `WPF_REG_MGMT: s_next.rdata[0] = s_reg.host_only;
        `WPF_REG_RA0L: s_next.rdata = s_reg.ra0[31:0];
        `WPF_REG_RA0H: begin
          s_next.rdata[15:0] = s_reg.ra0[47:32];
          s_next.rdata[`WPF_RA_VALID_BIT] = s_reg.ra0_v;
        end
        `WPF_REG_MTA0: s_next.rdata = s_reg.mta[31:0];
        `WPF_REG_MTA1: s_next.rdata = s_reg.mta[63:32];
        `WPF_REG_PLEN: s_next.rdata[15:0] = plen;
        default: begin
          // Stored frame window; hidden while host wake is still set
          if (avs_address[6] && !s_reg.host_wake) s_next.rdata[7:0] = pkt_byte;
        end
      endcase
    end
    if (wr_acc) begin
      case (avs_address)
        `WPF_REG_CTRL: begin
          s_next.mode_en = avs_writedata[`WPF_CTRL_MODE_BIT];
          s_next.host_wake = avs_writedata[`WPF_CTRL_HOST_BIT];
        end
        `WPF_REG_STORE: s_next.store_en = avs_writedata[`WPF_STORE_EN_BIT];
        `WPF_REG_WFC: s_next.wfc = avs_writedata[11:0];
        `WPF_REG_RECEIVE_CONTROL: begin
          s_next.mc_off = avs_writedata[`WPF_RECEIVE_CONTROL_MCOFF_LSB +: 2];
          s_next.bam = avs_writedata[`WPF_RECEIVE_CONTROL_BAM_BIT];
        end
        `WPF_REG_MGMT: s_next.host_only = avs_writedata[0];
        `WPF_REG_RA0L: s_next.ra0[31:0] = avs_writedata;
        `WPF_REG_RA0H: begin
          s_next.ra0[47:32] = avs_writedata[15:0];
          s_next.ra0_v = avs_writedata[`WPF_RA_VALID_BIT];
        end
        `WPF_REG_MTA0: s_next.mta[31:0] = avs_writedata;
        `WPF_REG_MTA1: s_next.mta[63:32] = avs_writedata;
        default: s_next.init = s_reg.init;
      endcase
    end

    // Station address from nonvolatile store after reset release
    s_next.init = 1'b1;
    if (!s_reg.init && nvm_pattern_wake_en) begin
      s_next.ra0 = nvm_station_addr;
      s_next.ra0_v = 1'b1;
    end

    // Receive front end: destination bytes and end-of-frame facts
    s_next.eval = rx_valid && rx_eof;
    if (rx_valid) begin
      if (rx_sof || s_reg.bcnt != 3'h6) s_next.da = {s_reg.da[39:0], rx_data};
      if (rx_sof) s_next.bcnt = 3'h1;
      else if (s_reg.bcnt != 3'h6) s_next.bcnt = s_reg.bcnt + 3'h1;
      if (rx_eof) begin
        s_next.ev_crc = rx_crc_ok;
        s_next.ev_mgmt = mgmt_filter_pass;
        s_next.ev_m2h = mgmt_to_host;
      end
    end
    s_next.link_d = link_up;

    // Sticky status: set wins over a software clear
    if (wr_acc && avs_address == `WPF_REG_WSTAT) s_next.wstat = s_reg.wstat & ~avs_writedata[4:0];
    s_next.wstat = s_next.wstat | hits;
    if (link_hit) s_next.wstat[`WPF_ST_LINK] = 1'b1;

    // Resend timer
    expire = s_reg.pend && !hw_chg && (s_reg.tmr == 24'(RESEND_CYCLES - 1));
    if (!s_reg.pend || hw_chg || expire) s_next.tmr = 24'h0;
    else s_next.tmr = s_reg.tmr + 24'h1;
    if ((|hits) || link_hit) s_next.pend = 1'b1;
    else if (!s_next.mode_en || s_next.wstat == 5'h0) s_next.pend = 1'b0;
    s_next.wake_ev = (|hits) || link_hit || expire;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.waitreq <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = s_reg.waitreq;
  assign wake_event = s_reg.wake_ev;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_mode_gate;
    wake_event |-> $past(s_reg.mode_en);
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("wake without wake mode");

  property p_sticky;
    !$past(wr_acc && avs_address == `WPF_REG_WSTAT) |-> (s_reg.wstat & $past(s_reg.wstat)) == $past(s_reg.wstat);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");

  property p_bcast;
    qual && s_reg.wfc[`WPF_ST_BC] && (&s_reg.da) && s_reg.bam |=> s_reg.wstat[`WPF_ST_BC] && wake_event;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast wake missed");

  property p_exact;
    qual && s_reg.wfc[`WPF_ST_EXACT] && s_reg.ra0_v && s_reg.da == s_reg.ra0 |=> s_reg.wstat[`WPF_ST_EXACT];
  endproperty
  a_exact: assert property (p_exact) else $error("exact wake missed");

  property p_link;
    s_reg.mode_en && s_reg.wfc[`WPF_ST_LINK] && link_up != s_reg.link_d |=> s_reg.wstat[`WPF_ST_LINK] && wake_event;
  endproperty
  a_link: assert property (p_link) else $error("link wake missed");

  property p_enable;
    $rose(s_reg.wstat[`WPF_ST_MC]) |-> $past(s_reg.wfc[`WPF_ST_MC]);
  endproperty
  a_enable: assert property (p_enable) else $error("disabled filter fired");

  property p_len_zero;
    !captured |-> plen == 16'h0;
  endproperty
  a_len_zero: assert property (p_len_zero) else $error("length without frame");

  property p_clear;
    pclr && !commit |=> !captured ##1 !captured || $past(commit);
  endproperty
  a_clear: assert property (p_clear) else $error("store clear ignored");

  property p_resend;
    expire |=> wake_event && s_reg.tmr == 24'h0;
  endproperty
  a_resend: assert property (p_resend) else $error("resend missing");

  property p_mgmt;
    s_reg.eval && s_reg.ev_mgmt && s_reg.wfc[`WPF_WFC_NOMGMT_BIT] && !(s_reg.host_only && s_reg.ev_m2h)
      && !link_hit && !expire |=> !wake_event;
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("management frame woke host");

  property p_bus;
    req && s_reg.waitreq |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer timing wrong");

  c_pattern: cover property (hits[`WPF_ST_PAT] ##1 wake_event);
  c_store: cover property (commit ##1 captured);
  c_resend: cover property (expire);
  c_multi: cover property (hits[`WPF_ST_BC] && hits[`WPF_ST_PAT]);
endmodule
`default_nettype wire

/* File: testbench/wpf_lan_model.sv */
// Far-side model: frame source and wake event receiver
`timescale 1ns/1ns
`default_nettype none
module wpf_lan_model (
  // Clock
  input wire logic clk,
  // Frame stream toward the filter
  output logic rx_valid,
  output logic rx_sof,
  output logic rx_eof,
  output wpf_pkg::wpf_byte_t rx_data,
  output logic rx_crc_ok,
  output logic mgmt_filter_pass,
  output logic mgmt_to_host,
  // Wake from the filter
  input wire logic wake_event
);
  import wpf_pkg::*;
  int wake_cnt = 0;
  initial begin
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_data = 8'h00;
    rx_crc_ok = 1'b0;
    mgmt_filter_pass = 1'b0;
    mgmt_to_host = 1'b0;
  end
  // Wake pulses are one cycle wide
  always @(posedge clk) begin
    if (wake_event === 1'b1) begin
      wake_cnt <= wake_cnt + 1;
    end
  end
  task automatic send(input wpf_byte_t fr[$], input logic crc, input logic mg, input logic mh);
    for (int i = 0; i < fr.size(); i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_eof <= (i == fr.size() - 1);
      rx_data <= fr[i];
      rx_crc_ok <= crc;
      mgmt_filter_pass <= mg;
      mgmt_to_host <= mh;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    rx_eof <= 1'b0;
    rx_data <= ~fr[fr.size() - 1];
    rx_crc_ok <= ~crc;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the wake packet filter
`timescale 1ns/1ns
`default_nettype none
`include "wpf_params.svh"
module tb_top;
  import wpf_pkg::*;
  localparam logic [47:0] STA = 48'h02a1b2c3d4e5;
  localparam logic [47:0] BC = 48'hffffffffffff;
  logic clk, rst_n, avs_read, avs_write, link_up, nvm_pattern_wake_en, wake_event;
  logic rx_valid, rx_sof, rx_eof, rx_crc_ok, mgmt_filter_pass, mgmt_to_host, avs_waitrequest;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [47:0] nvm_station_addr;
  wpf_byte_t rx_data;
  wpf_byte_t fr[$];
  int err_total, samples_checked, c0;
  wpf_top #(.RESEND_CYCLES(200)) i_wpf_top (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_data(rx_data), .rx_crc_ok(rx_crc_ok), .mgmt_filter_pass(mgmt_filter_pass),
    .mgmt_to_host(mgmt_to_host), .link_up(link_up), .nvm_pattern_wake_en(nvm_pattern_wake_en),
    .nvm_station_addr(nvm_station_addr), .wake_event(wake_event));
  wpf_lan_model i_wpf_lan_model (.clk(clk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
    .rx_data(rx_data), .rx_crc_ok(rx_crc_ok), .mgmt_filter_pass(mgmt_filter_pass),
    .mgmt_to_host(mgmt_to_host), .wake_event(wake_event));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****************************************
  // Bus, compare and closing tasks
  // ****************************************
  task automatic close_out();
    $display("Checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus_go(input logic [6:0] a, input logic rd, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      $display("Error bus wait expected answer seen none");
      close_out();
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic bus_rd(input logic [6:0] a, output logic [31:0] r);
    bus_go(a, 1'b1, 32'h0, r);
  endtask
  task automatic bus_wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus_go(a, 1'b0, d, r);
  endtask
  // ****************************************
  // Frame building and wake checks
  // ****************************************
  task automatic mk_frame(input logic [47:0] da, input int pad);
    fr = {};
    for (int i = 5; i >= 0; i--) fr.push_back(da[8*i +: 8]);
    repeat (6) fr.push_back(8'h02);
    fr.push_back(8'h08);
    fr.push_back(8'h00);
    repeat (pad) fr.push_back(8'h3c);
  endtask
  task automatic add_pat(input int nsync, input int ncp, input logic [47:0] a);
    repeat (nsync) fr.push_back(8'hff);
    repeat (ncp) for (int i = 5; i >= 0; i--) fr.push_back(a[8*i +: 8]);
    repeat (4) fr.push_back(8'h3c);
  endtask
  task automatic settle_chk(input int ew, input logic [4:0] es);
    repeat (6) @(posedge clk);
    chk_word("wake count", 32'(ew), 32'(i_wpf_lan_model.wake_cnt - c0));
    bus_rd(`WPF_REG_WSTAT, q);
    chk_word("wake status", {27'h0, es}, q);
    bus_wr(`WPF_REG_WSTAT, 32'h1f);
  endtask
  task automatic frame_chk(input logic crc, input logic mg, input logic mh, input int ew, input logic [4:0] es);
    c0 = i_wpf_lan_model.wake_cnt;
    i_wpf_lan_model.send(fr, crc, mg, mh);
    settle_chk(ew, es);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    link_up = 1'b0;
    nvm_pattern_wake_en = 1'b1;
    nvm_station_addr = STA;
    err_total = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus_rd(`WPF_REG_PLEN, q);
    chk_word("stored length", 32'h0, q);
    bus_rd(7'h3f, q);
    chk_word("unmapped word", 32'h0, q);
    bus_rd(`WPF_REG_RA0L, q);
    chk_word("address zero low", STA[31:0], q);
    bus_rd(`WPF_REG_RA0H, q);
    chk_word("address zero high", {16'h0, STA[47:32]}, q & 32'h0000ffff);
    bus_wr(`WPF_REG_RECEIVE_CONTROL, 32'h20);
    bus_wr(`WPF_REG_WFC, 32'h10);
    mk_frame(BC, 10);
    frame_chk(1'b1, 1'b0, 1'b0, 0, 5'h00);
    bus_wr(`WPF_REG_STORE, 32'h10);
    bus_wr(`WPF_REG_CTRL, 32'h14);
    frame_chk(1'b1, 1'b0, 1'b0, 1, 5'h10);
    bus_rd(7'h40, q);
    chk_word("stored byte hidden", 32'h0, q);
    bus_wr(`WPF_REG_CTRL, 32'h04);
    bus_rd(`WPF_REG_PLEN, q);
    chk_word("stored length", 32'd24, q);
    bus_rd(7'h40, q);
    chk_word("stored byte 0", 32'hff, q);
    bus_rd(7'h4c, q);
    chk_word("stored byte 12", 32'h08, q);
    bus_wr(`WPF_REG_PCLR, 32'h1);
    bus_rd(`WPF_REG_PLEN, q);
    chk_word("stored length", 32'h0, q);
    bus_wr(`WPF_REG_STORE, 32'h0);
    frame_chk(1'b0, 1'b0, 1'b0, 0, 5'h00);
    bus_wr(`WPF_REG_WFC, 32'h0);
    frame_chk(1'b1, 1'b0, 1'b0, 0, 5'h00);
    bus_wr(`WPF_REG_RA0H, {1'b1, 15'h0, STA[47:32]});
    bus_wr(`WPF_REG_WFC, 32'h06);
    mk_frame(STA, 3);
    add_pat(7, 16, STA);
    frame_chk(1'b1, 1'b0, 1'b0, 1, 5'h06);
    bus_wr(`WPF_REG_RECEIVE_CONTROL, 32'h0);
    bus_wr(`WPF_REG_WFC, 32'h02);
    mk_frame(BC, 1);
    add_pat(6, 16, STA);
    frame_chk(1'b1, 1'b0, 1'b0, 1, 5'h02);
    mk_frame(BC, 1);
    add_pat(5, 16, STA);
    frame_chk(1'b1, 1'b0, 1'b0, 0, 5'h00);
    mk_frame(BC, 1);
    add_pat(6, 15, STA);
    frame_chk(1'b1, 1'b0, 1'b0, 0, 5'h00);
    mk_frame(48'h0200000000a1, 1);
    add_pat(6, 16, 48'h0200000000a1);
    frame_chk(1'b1, 1'b0, 1'b0, 0, 5'h00);
    bus_wr(`WPF_REG_RECEIVE_CONTROL, 32'h08);
    bus_wr(`WPF_REG_MTA0, 32'h20);
    bus_wr(`WPF_REG_WFC, 32'h08);
    mk_frame(48'h01005e000014, 4);
    frame_chk(1'b1, 1'b0, 1'b0, 1, 5'h08);
    mk_frame(48'h01005e000018, 4);
    frame_chk(1'b1, 1'b0, 1'b0, 0, 5'h00);
    bus_wr(`WPF_REG_RECEIVE_CONTROL, 32'h20);
    bus_wr(`WPF_REG_WFC, 32'h810);
    mk_frame(BC, 4);
    frame_chk(1'b1, 1'b1, 1'b0, 0, 5'h00);
    bus_wr(`WPF_REG_MGMT, 32'h1);
    frame_chk(1'b1, 1'b1, 1'b1, 1, 5'h10);
    bus_wr(`WPF_REG_WFC, 32'h01);
    c0 = i_wpf_lan_model.wake_cnt;
    link_up <= 1'b1;
    settle_chk(1, 5'h01);
    bus_wr(`WPF_REG_WFC, 32'h0);
    c0 = i_wpf_lan_model.wake_cnt;
    link_up <= 1'b0;
    settle_chk(0, 5'h00);
    bus_wr(`WPF_REG_WFC, 32'h10);
    c0 = i_wpf_lan_model.wake_cnt;
    i_wpf_lan_model.send(fr, 1'b1, 1'b0, 1'b0);
    repeat (450) @(posedge clk);
    chk_word("wake repeats", 32'd3, 32'(i_wpf_lan_model.wake_cnt - c0));
    bus_wr(`WPF_REG_WSTAT, 32'h1f);
    c0 = i_wpf_lan_model.wake_cnt;
    repeat (450) @(posedge clk);
    chk_word("wake after clear", 32'd0, 32'(i_wpf_lan_model.wake_cnt - c0));
    // Mid-run resets with the strap low, then high with a new address
    rst_n <= 1'b0;
    nvm_pattern_wake_en <= 1'b0;
    nvm_station_addr <= 48'h0211223344a5;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus_rd(`WPF_REG_RA0L, q);
    chk_word("address zero low", 32'h0, q);
    rst_n <= 1'b0;
    nvm_pattern_wake_en <= 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus_rd(`WPF_REG_RA0L, q);
    chk_word("address zero low", 32'h223344a5, q);
    bus_rd(`WPF_REG_RA0H, q);
    chk_word("address zero high", 32'h80000211, q);
    close_out();
  end
endmodule
`default_nettype wire
